// file: rtl/bmc_pkg.sv
// package: register map, field positions, reset values and timing of the barometer control block
package bmc_pkg;
  // ==========================================
  // register offsets
  localparam logic [6:0] REF_LOW_ADDR = 7'h08;
  localparam logic [6:0] REF_MID_ADDR = 7'h09;
  localparam logic [6:0] REF_HIGH_ADDR = 7'h0A;
  localparam logic [6:0] IDENTITY_ADDR = 7'h0F;
  localparam logic [6:0] AVG_CFG_ADDR = 7'h10;
  localparam logic [6:0] MAIN_CTRL_ADDR = 7'h20;
  localparam logic [6:0] AUX_CTRL_ADDR = 7'h21;
  localparam logic [6:0] STATUS_ADDR = 7'h27;
  localparam logic [6:0] POUT_LOW_ADDR = 7'h28;
  localparam logic [6:0] POUT_MID_ADDR = 7'h29;
  localparam logic [6:0] POUT_HIGH_ADDR = 7'h2A;
  localparam logic [6:0] OFFS_LOW_ADDR = 7'h39;
  localparam logic [6:0] OFFS_HIGH_ADDR = 7'h3A;
  // ==========================================
  // reset values
  localparam logic [7:0] AVG_CFG_RESET = 8'h0F;
  localparam logic [7:0] AVG_CFG_MASK = 8'h0F;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] IDENTITY_DEFAULT = 8'h5A; // arbitrary value
  // ==========================================
  // main_control fields
  localparam int POWER_ON_BIT = 7;
  localparam int RATE_HI = 6;
  localparam int RATE_LO = 4;
  localparam int DIFF_BIT = 3;
  localparam int HOLD_BIT = 2;
  localparam int AZ_CLEAR_BIT = 1;
  localparam int THREE_WIRE_BIT = 0;
  // aux_control fields
  localparam int REBOOT_BIT = 7;
  localparam int FIFO_EN_BIT = 6;
  localparam int WATERMARK_BIT = 5;
  localparam int MEAN_DEC_BIT = 4;
  localparam int TWO_WIRE_DIS_BIT = 3;
  localparam int SOFT_RESET_BIT = 2;
  localparam int AUTOZERO_BIT = 1;
  localparam int ONE_SHOT_BIT = 0;
  // output rate codes
  localparam logic [2:0] RATE_ONE_SHOT = 3'h0;
  localparam logic [2:0] RATE_RESERVED = 3'h5;
  // ==========================================
  // timing at 20 MHz
  localparam int CLK_HZ = 20000000;
  localparam real REBOOT_MS = 2.2;
  localparam int REBOOT_CYCLES = int'(REBOOT_MS * CLK_HZ / 1000.0);
  localparam real SOFT_RESET_US = 4.0;
  localparam int SOFT_RESET_CYCLES = int'(SOFT_RESET_US * CLK_HZ / 1000000.0);
  localparam int SAMPLE_CYCLES_DEFAULT = 64;
  localparam int TRIM_WORDS = 8;
endpackage : bmc_pkg

// file: rtl/bmc_sample_if.sv
// interface: sample request and result between control and sampler
`timescale 1ns/1ps
`default_nettype none
interface bmc_sample_if;
  logic start;
  logic [9:0] count;
  logic busy;
  logic done;
  logic [23:0] pressure;
  modport ctrl (output start, output count, input busy, input done, input pressure);
  modport smp (input start, input count, output busy, output done, output pressure);
endinterface : bmc_sample_if
`default_nettype wire

// file: rtl/bmc_sampler.sv
// sampler: averages the raw pressure over a chosen number of internal samples
`timescale 1ns/1ps
`default_nettype none
module bmc_sampler #(
  parameter int SAMPLE_CYCLES = bmc_pkg::SAMPLE_CYCLES_DEFAULT
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // raw sensor word
  input wire logic [23:0] raw_pressure,
  // request and result
  bmc_sample_if.smp s
);
  if (SAMPLE_CYCLES < 1 || SAMPLE_CYCLES > 65536) begin : g_bad_cycles
    $error("sample cycles out of range");
  end
  logic [9:0] left_r;
  logic [15:0] tick_r;
  logic [33:0] acc_r;
  logic [9:0] n_r;
  logic done_r;
  logic [23:0] out_r;
  assign s.busy = (left_r != 10'h000);
  assign s.done = done_r;
  assign s.pressure = out_r;
  // ==========================================
  // accumulation
  always_ff @(posedge clk) begin
    done_r <= 1'b0;
    if (rst) begin
      left_r <= 10'h000;
      tick_r <= 16'h0000;
      acc_r <= 34'h0;
      n_r <= 10'h000;
      out_r <= 24'h0000_00;
    end else if (s.start && left_r == 10'h000) begin
      left_r <= s.count;
      n_r <= s.count;
      acc_r <= 34'h0;
      tick_r <= 16'(SAMPLE_CYCLES - 1);
    end else if (left_r != 10'h000) begin
      if (tick_r != 16'h0000) begin
        tick_r <= tick_r - 16'h0001;
      end else begin
        tick_r <= 16'(SAMPLE_CYCLES - 1);
        acc_r <= acc_r + {{10{raw_pressure[23]}}, raw_pressure};
        left_r <= left_r - 10'h001;
        if (left_r == 10'h001) begin
          done_r <= 1'b1;
          out_r <= 24'(($signed(acc_r + {{10{raw_pressure[23]}}, raw_pressure}))
                       / $signed({24'h0, n_r}));
        end
      end
    end
  end
endmodule : bmc_sampler
`default_nettype wire

// file: rtl/bmc_trim_loader.sv
// trim loader: copies nonvolatile trim words into working trim registers
`timescale 1ns/1ps
`default_nettype none
module bmc_trim_loader #(
  parameter int BOOT_CYCLES = bmc_pkg::REBOOT_CYCLES,
  parameter int WORDS = bmc_pkg::TRIM_WORDS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic start,
  output logic busy,
  // trim data
  input wire logic [8*WORDS-1:0] nv_trim,
  output logic [8*WORDS-1:0] trim
);
  if (BOOT_CYCLES < WORDS || WORDS < 1 || WORDS > 256
      || BOOT_CYCLES > 16777216) begin : g_bad_boot
    $error("boot time or trim word count out of range");
  end
  logic [23:0] cnt_r;
  logic run_r;
  assign busy = run_r;
  // ==========================================
  // copy sequence
  always_ff @(posedge clk) begin
    if (rst) begin
      run_r <= 1'b1;
      cnt_r <= 24'h0000_00;
      trim <= '0;
    end else if (run_r) begin
      if (cnt_r < 24'(WORDS)) begin
        trim[8*cnt_r[7:0] +: 8] <= nv_trim[8*cnt_r[7:0] +: 8];
      end
      if (cnt_r == 24'(BOOT_CYCLES - 1)) begin
        run_r <= 1'b0;
        cnt_r <= 24'h0000_00;
      end else begin
        cnt_r <= cnt_r + 24'h0000_01;
      end
    end else if (start) begin
      run_r <= 1'b1;
    end
  end
endmodule : bmc_trim_loader
`default_nettype wire

// file: rtl/bmc_ctrl.sv
// barometer measurement control and configuration registers
`timescale 1ns/1ps
`default_nettype none
module bmc_ctrl #(
  parameter int BOOT_CYCLES = bmc_pkg::REBOOT_CYCLES,
  parameter int SAMPLE_CYCLES = bmc_pkg::SAMPLE_CYCLES_DEFAULT,
  parameter int SECOND_CYCLES = bmc_pkg::CLK_HZ,
  parameter logic [7:0] IDENTITY = bmc_pkg::IDENTITY_DEFAULT // arbitrary value
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port from the serial interface
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // sensor and trim
  input wire logic [23:0] raw_pressure,
  input wire logic [8*bmc_pkg::TRIM_WORDS-1:0] nv_trim,
  output logic [8*bmc_pkg::TRIM_WORDS-1:0] trim,
  // configuration outputs
  output logic three_wire_select,
  output logic two_wire_disable,
  output logic fifo_enable,
  output logic watermark_monitor_enable,
  output logic differential_enable,
  output logic [1:0] temp_average_select,
  output logic boot_busy
);
  if (SECOND_CYCLES < 25 || SAMPLE_CYCLES < 1
      || SECOND_CYCLES > 100000000) begin : g_bad_timing
    $error("bad timing parameters");
  end
  localparam int SR_CYC = bmc_pkg::SOFT_RESET_CYCLES;
  typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_WAIT} bmc_conv_e;

  logic [23:0] ref_r;
  logic [15:0] offs_r;
  logic [7:0] avg_r;
  logic [7:0] main_r;
  logic [7:0] aux_r;
  logic [23:0] pout_r;
  logic [23:0] meas_r;
  logic meas_new_r;
  logic [1:0] rd_seen_r;
  logic p_avail_r;
  logic [7:0] sr_cnt_r;
  logic [31:0] rate_cnt_r;
  logic [31:0] sec_cnt_r;
  bmc_conv_e state_r;
  logic sr_act;
  logic boot_start;
  logic rate_tick;
  logic [31:0] period;
  logic [23:0] diffed;
  bmc_sample_if sif ();

  // ==========================================
  // decode helpers
  function automatic logic hit(input logic [6:0] a, input logic [6:0] b);
    return reg_wr && (a == b);
  endfunction : hit

  function automatic logic [9:0] p_count(input logic [1:0] c);
    case (c)
      2'b00: return 10'd8;
      2'b01: return 10'd32;
      2'b10: return 10'd128;
      default: return 10'd511;
    endcase
  endfunction : p_count

  assign sr_act = (sr_cnt_r != 8'h00);
  assign boot_start = hit(reg_addr, bmc_pkg::AUX_CTRL_ADDR)
    && reg_wdata[bmc_pkg::REBOOT_BIT];

  // ==========================================
  // configuration registers
  always_ff @(posedge clk) begin
    if (rst || sr_act) begin
      avg_r <= bmc_pkg::AVG_CFG_RESET;
      main_r <= bmc_pkg::CTRL_RESET;
      aux_r <= bmc_pkg::CTRL_RESET;
    end else begin
      if (hit(reg_addr, bmc_pkg::AVG_CFG_ADDR)) begin
        avg_r <= reg_wdata & bmc_pkg::AVG_CFG_MASK;
      end
      if (hit(reg_addr, bmc_pkg::MAIN_CTRL_ADDR)) begin
        main_r <= reg_wdata;
        main_r[bmc_pkg::AZ_CLEAR_BIT] <= 1'b0;
      end
      if (hit(reg_addr, bmc_pkg::AUX_CTRL_ADDR)) begin
        aux_r <= reg_wdata;
        aux_r[bmc_pkg::SOFT_RESET_BIT] <= 1'b0;
      end else begin
        aux_r[bmc_pkg::REBOOT_BIT] <= boot_busy;
        if (sif.done && state_r == ST_CONV && main_r[6:4] == bmc_pkg::RATE_ONE_SHOT) begin
          aux_r[bmc_pkg::ONE_SHOT_BIT] <= 1'b0;
        end
      end
    end
  end

  // soft reset timer
  always_ff @(posedge clk) begin
    if (rst) begin
      sr_cnt_r <= 8'h00;
    end else if (hit(reg_addr, bmc_pkg::AUX_CTRL_ADDR) && reg_wdata[bmc_pkg::SOFT_RESET_BIT]) begin
      sr_cnt_r <= 8'(SR_CYC - 1);
    end else if (sr_act) begin
      sr_cnt_r <= sr_cnt_r - 8'h01;
    end
  end

  // ==========================================
  // reference and offset registers
  always_ff @(posedge clk) begin
    if (rst || sr_act) begin
      ref_r <= 24'h0000_00;
      offs_r <= 16'h0000;
    end else if (hit(reg_addr, bmc_pkg::MAIN_CTRL_ADDR) && reg_wdata[bmc_pkg::AZ_CLEAR_BIT]) begin
      ref_r <= 24'h0000_00;
      offs_r <= 16'h0000;
    end else if (hit(reg_addr, bmc_pkg::AUX_CTRL_ADDR) && reg_wdata[bmc_pkg::AUTOZERO_BIT]
                 && !aux_r[bmc_pkg::AUTOZERO_BIT]) begin
      ref_r <= meas_r;
    end else begin
      if (hit(reg_addr, bmc_pkg::REF_LOW_ADDR)) ref_r[7:0] <= reg_wdata;
      if (hit(reg_addr, bmc_pkg::REF_MID_ADDR)) ref_r[15:8] <= reg_wdata;
      if (hit(reg_addr, bmc_pkg::REF_HIGH_ADDR)) ref_r[23:16] <= reg_wdata;
      if (hit(reg_addr, bmc_pkg::OFFS_LOW_ADDR)) offs_r[7:0] <= reg_wdata;
      if (hit(reg_addr, bmc_pkg::OFFS_HIGH_ADDR)) offs_r[15:8] <= reg_wdata;
    end
  end

  // ==========================================
  // conversion sequencing
  always_comb begin
    case (main_r[6:4])
      3'h1: period = 32'(SECOND_CYCLES);
      3'h2: period = 32'(SECOND_CYCLES / 7);
      3'h3: period = 32'(SECOND_CYCLES * 2 / 25);
      default: period = 32'(SECOND_CYCLES / 25);
    endcase
  end

  logic running;
  assign running = main_r[bmc_pkg::POWER_ON_BIT] && !boot_busy
    && main_r[6:4] != bmc_pkg::RATE_RESERVED && main_r[6:4] < 3'h5;
  assign rate_tick = running && main_r[6:4] != bmc_pkg::RATE_ONE_SHOT
    && rate_cnt_r >= period - 32'h1;

  always_ff @(posedge clk) begin
    if (rst || !running || main_r[6:4] == bmc_pkg::RATE_ONE_SHOT) begin
      rate_cnt_r <= 32'h0;
    end else begin
      rate_cnt_r <= rate_tick ? 32'h0 : rate_cnt_r + 32'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || sr_act) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (sif.start) begin
            state_r <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (sif.done) state_r <= ST_WAIT;
        end
        ST_WAIT: begin
          state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end
  assign sif.start = (state_r == ST_IDLE) && running && !sif.busy
    && (rate_tick || (main_r[6:4] == bmc_pkg::RATE_ONE_SHOT
    && aux_r[bmc_pkg::ONE_SHOT_BIT]));
  assign sif.count = p_count(avg_r[1:0]);

  // ==========================================
  // output data path
  assign diffed = main_r[bmc_pkg::DIFF_BIT] || aux_r[bmc_pkg::AUTOZERO_BIT]
    ? meas_r - ref_r : meas_r;

  always_ff @(posedge clk) begin
    if (rst || sr_act) begin
      meas_r <= 24'h0000_00;
      meas_new_r <= 1'b0;
      sec_cnt_r <= 32'h0;
    end else begin
      meas_new_r <= 1'b0;
      sec_cnt_r <= (sec_cnt_r >= 32'(SECOND_CYCLES - 1)) ? 32'h0 : sec_cnt_r + 32'h1;
      if (sif.done) meas_r <= sif.pressure;
      if (aux_r[bmc_pkg::MEAN_DEC_BIT]) begin
        meas_new_r <= (sec_cnt_r == 32'h0);
      end else begin
        meas_new_r <= sif.done;
      end
    end
  end

  // hold-until-read: track low and high part reads
  always_ff @(posedge clk) begin
    if (rst || sr_act) begin
      pout_r <= 24'h0000_00;
      rd_seen_r <= 2'b11;
      p_avail_r <= 1'b0;
    end else begin
      if (meas_new_r && (!main_r[bmc_pkg::HOLD_BIT] || rd_seen_r == 2'b11)) begin
        pout_r <= diffed;
        rd_seen_r <= 2'b00;
        p_avail_r <= 1'b1;
      end else if (reg_rd) begin
        if (reg_addr == bmc_pkg::POUT_LOW_ADDR) rd_seen_r[0] <= 1'b1;
        if (reg_addr == bmc_pkg::POUT_HIGH_ADDR) begin
          rd_seen_r[1] <= 1'b1;
          p_avail_r <= 1'b0;
        end
      end
    end
  end

  // ==========================================
  // read multiplexer
  always_comb begin
    if (reg_addr == bmc_pkg::REF_LOW_ADDR) reg_rdata = ref_r[7:0];
    else if (reg_addr == bmc_pkg::REF_MID_ADDR) reg_rdata = ref_r[15:8];
    else if (reg_addr == bmc_pkg::REF_HIGH_ADDR) reg_rdata = ref_r[23:16];
    else if (reg_addr == bmc_pkg::IDENTITY_ADDR) reg_rdata = IDENTITY;
    else if (reg_addr == bmc_pkg::AVG_CFG_ADDR) reg_rdata = avg_r;
    else if (reg_addr == bmc_pkg::MAIN_CTRL_ADDR) reg_rdata = main_r;
    else if (reg_addr == bmc_pkg::AUX_CTRL_ADDR) reg_rdata = aux_r;
    else if (reg_addr == bmc_pkg::STATUS_ADDR) reg_rdata = {6'h00, p_avail_r, 1'b0};
    else if (reg_addr == bmc_pkg::POUT_LOW_ADDR) reg_rdata = pout_r[7:0];
    else if (reg_addr == bmc_pkg::POUT_MID_ADDR) reg_rdata = pout_r[15:8];
    else if (reg_addr == bmc_pkg::POUT_HIGH_ADDR) reg_rdata = pout_r[23:16];
    else if (reg_addr == bmc_pkg::OFFS_LOW_ADDR) reg_rdata = offs_r[7:0];
    else if (reg_addr == bmc_pkg::OFFS_HIGH_ADDR) reg_rdata = offs_r[15:8];
    else reg_rdata = 8'h00;
  end

  // ==========================================
  // configuration outputs
  assign three_wire_select = main_r[bmc_pkg::THREE_WIRE_BIT];
  assign two_wire_disable = aux_r[bmc_pkg::TWO_WIRE_DIS_BIT];
  assign fifo_enable = aux_r[bmc_pkg::FIFO_EN_BIT];
  assign watermark_monitor_enable = aux_r[bmc_pkg::WATERMARK_BIT];
  assign differential_enable = main_r[bmc_pkg::DIFF_BIT];
  assign temp_average_select = avg_r[3:2];

  // ==========================================
  // submodules
  bmc_sampler #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_smp (
    .clk(clk),
    .rst(rst),
    .raw_pressure(raw_pressure),
    .s(sif)
  );

  bmc_trim_loader #(.BOOT_CYCLES(BOOT_CYCLES), .WORDS(bmc_pkg::TRIM_WORDS)) u_trim (
    .clk(clk),
    .rst(rst),
    .start(boot_start),
    .busy(boot_busy),
    .nv_trim(nv_trim),
    .trim(trim)
  );
endmodule : bmc_ctrl
`default_nettype wire

// file: sim/bmc_ctrl_asserts.sv
// checker: port assertions for the barometer control block
`timescale 1ns/1ps
`default_nettype none
module bmc_ctrl_asserts #(
  parameter int BOOT_CYCLES = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // sensor and trim
  input wire logic [23:0] raw_pressure,
  input wire logic [8*bmc_pkg::TRIM_WORDS-1:0] nv_trim,
  input wire logic [8*bmc_pkg::TRIM_WORDS-1:0] trim,
  // configuration
  input wire logic three_wire_select,
  input wire logic two_wire_disable,
  input wire logic fifo_enable,
  input wire logic watermark_monitor_enable,
  input wire logic differential_enable,
  input wire logic [1:0] temp_average_select,
  input wire logic boot_busy
);
  localparam int SR_MAX = 82;
  logic [15:0] busy_cnt_r;
  logic aux_wr;
  logic main_wr;
  // ==========================================
  // helper logic
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_cnt_r <= 16'h0000;
    end else if (boot_busy) begin
      busy_cnt_r <= busy_cnt_r + 16'h0001;
    end else begin
      busy_cnt_r <= 16'h0000;
    end
  end
  assign aux_wr = reg_wr && reg_addr == bmc_pkg::AUX_CTRL_ADDR
    && !reg_wdata[bmc_pkg::SOFT_RESET_BIT];
  assign main_wr = reg_wr && reg_addr == bmc_pkg::MAIN_CTRL_ADDR;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ==========================================
  // sequences
  sequence s_sr_req;
    reg_wr && reg_addr == bmc_pkg::AUX_CTRL_ADDR && reg_wdata[bmc_pkg::SOFT_RESET_BIT];
  endsequence
  sequence s_cfg_default;
    temp_average_select == 2'b11 && !three_wire_select && !differential_enable
      && !fifo_enable && !two_wire_disable && !watermark_monitor_enable;
  endsequence
  sequence s_ref_wr;
    reg_wr && reg_addr == bmc_pkg::REF_HIGH_ADDR ##1 reg_addr == bmc_pkg::REF_HIGH_ADDR && !reg_wr;
  endsequence
  // ==========================================
  // assertions
  a_ref_high_rw: assert property (s_ref_wr |-> reg_rdata == $past(reg_wdata))
    else $error("reference high byte lost its written value");
  a_avg_rsvd_zero: assert property (reg_addr == bmc_pkg::AVG_CFG_ADDR |-> reg_rdata[7:4] == 4'h0)
    else $error("reserved averaging bits read nonzero");
  a_temp_avg_track: assert property (reg_wr && reg_addr == bmc_pkg::AVG_CFG_ADDR
    |=> temp_average_select == $past(reg_wdata[3:2]))
    else $error("temperature averaging output wrong");
  a_three_wire_track: assert property (main_wr |=> three_wire_select == $past(reg_wdata[0]))
    else $error("serial mode select output wrong");
  a_differential_enable_track: assert property (main_wr |=> differential_enable == $past(reg_wdata[3]))
    else $error("differential enable output wrong");
  a_az_clear_low: assert property (reg_addr == bmc_pkg::MAIN_CTRL_ADDR |-> !reg_rdata[1])
    else $error("autozero clear bit read as one");
  a_aux_outs_track: assert property (aux_wr |=> fifo_enable == $past(reg_wdata[6])
    && watermark_monitor_enable == $past(reg_wdata[5])
    && two_wire_disable == $past(reg_wdata[3]))
    else $error("aux control outputs wrong");
  a_soft_rst_cfg: assert property (s_sr_req |-> ##[1:SR_MAX] s_cfg_default)
    else $error("soft reset did not restore configuration");
  a_reboot_start: assert property (reg_wr && reg_addr == bmc_pkg::AUX_CTRL_ADDR
    && reg_wdata[bmc_pkg::REBOOT_BIT] |-> ##[1:2] boot_busy)
    else $error("reboot did not start the trim copy");
  a_boot_after_rst: assert property ($fell(rst) |-> ##[0:2] boot_busy)
    else $error("trim copy did not start after reset");
  a_boot_length: assert property ($fell(boot_busy) |-> busy_cnt_r >= BOOT_CYCLES - 2
    && busy_cnt_r <= BOOT_CYCLES + 2)
    else $error("trim copy length wrong");
  a_trim_loaded: assert property ($fell(boot_busy) |-> ##[0:1] trim == nv_trim)
    else $error("trim copy ended with wrong trim");
endmodule : bmc_ctrl_asserts
bind bmc_ctrl bmc_ctrl_asserts #(.BOOT_CYCLES(BOOT_CYCLES)) chk_u (
  .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .raw_pressure(raw_pressure),
  .nv_trim(nv_trim), .trim(trim), .three_wire_select(three_wire_select),
  .two_wire_disable(two_wire_disable), .fifo_enable(fifo_enable),
  .watermark_monitor_enable(watermark_monitor_enable),
  .differential_enable(differential_enable),
  .temp_average_select(temp_average_select), .boot_busy(boot_busy)
);
`default_nettype wire

// file: sim/bmc_host_model.sv
// host model: drives the register port as the serial host does
`timescale 1ns/1ps
`default_nettype none
module bmc_host_model (
  // clock
  input wire logic clk,
  // register port
  output logic reg_wr,
  output logic reg_rd,
  output logic [6:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 7'h00;
    reg_wdata = 8'h00;
  end
  // ==========================================
  // one byte write, an idle edge after it
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : wr
  // one byte read, data taken at the strobe edge
  task automatic rd(input logic [6:0] a, output logic [7:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    v = reg_rdata;
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask : rd
endmodule : bmc_host_model
`default_nettype wire

// file: sim/bmc_ctrl_tb_top.sv
// testbench: register, conversion, reset and trim checks of the control block
`timescale 1ns/1ps
`default_nettype none
module bmc_ctrl_tb_top;
  localparam int BOOT = 16;
  localparam logic [6:0] A_AUX = bmc_pkg::AUX_CTRL_ADDR;
  localparam logic [6:0] A_MAIN = bmc_pkg::MAIN_CTRL_ADDR;
  typedef struct packed {logic [6:0] a; logic [7:0] w; logic [7:0] e;} bmc_row_s;
  logic clk, rst, reg_wr, reg_rd, boot_busy;
  logic three_wire_select, two_wire_disable, fifo_enable, watermark_monitor_enable;
  logic differential_enable;
  logic [1:0] temp_average_select;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, d;
  logic [23:0] raw_pressure;
  logic [8*bmc_pkg::TRIM_WORDS-1:0] nv_trim, trim;
  int error_cnt, cmp_count, cyc;
  bmc_row_s rows [9];
  bmc_ctrl #(.BOOT_CYCLES(BOOT), .SAMPLE_CYCLES(1), .SECOND_CYCLES(100)) dut_u (
    .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .raw_pressure(raw_pressure),
    .nv_trim(nv_trim), .trim(trim), .three_wire_select(three_wire_select),
    .two_wire_disable(two_wire_disable), .fifo_enable(fifo_enable),
    .watermark_monitor_enable(watermark_monitor_enable),
    .differential_enable(differential_enable),
    .temp_average_select(temp_average_select), .boot_busy(boot_busy));
  bmc_host_model host_u (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  // ==========================================
  // clock and watchdog
  initial clk = 1'b0;
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      error_cnt++;
      stop_test();
    end
  end
  // ==========================================
  // helpers
  task automatic stop_test();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
    host_u.rd(a, d);
    chk({56'h0, d}, {56'h0, e});
  endtask : rdchk
  task automatic wait_boot();
    int k;
    k = 0;
    while (boot_busy !== 1'b0 && k < 200) begin
      @(posedge clk);
      k++;
    end
    chk({63'h0, boot_busy}, 64'h0);
  endtask : wait_boot
  task automatic shot(input logic [7:0] v);
    int k;
    logic [7:0] q;
    host_u.wr(A_AUX, v);
    q = 8'h01;
    k = 0;
    while (q[0] !== 1'b0 && k < 200) begin
      host_u.rd(A_AUX, q);
      k++;
    end
    chk({63'h0, q[0]}, 64'h0);
  endtask : shot
  // ==========================================
  // main sequence
  initial begin
    rst = 1'b1;
    cyc = 0;
    error_cnt = 0;
    cmp_count = 0;
    raw_pressure = 24'h12_3456;
    nv_trim = 64'h0123_4567_89ab_cdef;
    rows = '{'{bmc_pkg::REF_LOW_ADDR, 8'h3C, 8'h3C}, '{bmc_pkg::REF_MID_ADDR, 8'h7E, 8'h7E},
      '{bmc_pkg::REF_HIGH_ADDR, 8'hA5, 8'hA5}, '{bmc_pkg::AVG_CFG_ADDR, 8'hF6, 8'h06},
      '{A_MAIN, 8'h0D, 8'h0D}, '{A_AUX, 8'h78, 8'h78},
      '{bmc_pkg::IDENTITY_ADDR, 8'h00, bmc_pkg::IDENTITY_DEFAULT}, '{7'h11, 8'hFF, 8'h00},
      '{bmc_pkg::OFFS_LOW_ADDR, 8'h11, 8'h11}};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdchk(A_AUX, 8'h80);
    wait_boot();
    chk(trim, 64'h0123_4567_89ab_cdef);
    rdchk(bmc_pkg::AVG_CFG_ADDR, bmc_pkg::AVG_CFG_RESET);
    rdchk(A_MAIN, 8'h00);
    rdchk(A_AUX, 8'h00);
    // reference bytes go in before the differential enable row
    foreach (rows[i]) begin
      host_u.wr(rows[i].a, rows[i].w);
      rdchk(rows[i].a, rows[i].e);
    end
    chk({three_wire_select, differential_enable, fifo_enable, watermark_monitor_enable,
      two_wire_disable, temp_average_select}, 7'b111_1101);
    host_u.wr(A_MAIN, 8'h0F);
    rdchk(A_MAIN, 8'h0D);
    rdchk(bmc_pkg::REF_HIGH_ADDR, 8'h00);
    rdchk(bmc_pkg::REF_LOW_ADDR, 8'h00);
    rdchk(bmc_pkg::OFFS_LOW_ADDR, 8'h00);
    // soft reset first, reboot after it
    host_u.wr(A_AUX, 8'h04);
    repeat (90) @(posedge clk);
    rdchk(A_MAIN, 8'h00);
    rdchk(bmc_pkg::AVG_CFG_ADDR, 8'h0F);
    rdchk(A_AUX, 8'h00);
    nv_trim <= 64'hfedc_ba98_7654_3210;
    host_u.wr(A_AUX, 8'h80);
    rdchk(A_AUX, 8'h80);
    wait_boot();
    chk(trim, 64'hfedc_ba98_7654_3210);
    rdchk(A_AUX, 8'h00);
    // one-shot conversion, documented rate codes only
    host_u.wr(bmc_pkg::AVG_CFG_ADDR, 8'h0C);
    host_u.wr(A_MAIN, 8'h80);
    shot(8'h01);
    rdchk(bmc_pkg::STATUS_ADDR, 8'h02);
    rdchk(bmc_pkg::POUT_LOW_ADDR, 8'h56);
    rdchk(bmc_pkg::POUT_MID_ADDR, 8'h34);
    rdchk(bmc_pkg::POUT_HIGH_ADDR, 8'h12);
    rdchk(bmc_pkg::STATUS_ADDR, 8'h00);
    host_u.wr(A_AUX, 8'h02);
    rdchk(bmc_pkg::REF_LOW_ADDR, 8'h56);
    rdchk(bmc_pkg::REF_HIGH_ADDR, 8'h12);
    shot(8'h03);
    rdchk(bmc_pkg::POUT_LOW_ADDR, 8'h00);
    rdchk(bmc_pkg::POUT_HIGH_ADDR, 8'h00);
    // hold mode keeps a half-read result
    host_u.wr(A_MAIN, 8'h84);
    raw_pressure <= 24'h23_4567;
    shot(8'h01);
    rdchk(bmc_pkg::POUT_LOW_ADDR, 8'h67);
    raw_pressure <= 24'h34_5678;
    shot(8'h01);
    rdchk(bmc_pkg::POUT_HIGH_ADDR, 8'h23);
    // periodic conversions at rate code 001, then power-down stops them
    host_u.wr(A_MAIN, 8'h90);
    repeat (120) @(posedge clk);
    rdchk(bmc_pkg::STATUS_ADDR, 8'h02);
    rdchk(bmc_pkg::POUT_HIGH_ADDR, 8'h34);
    host_u.wr(A_MAIN, 8'h10);
    repeat (250) @(posedge clk);
    rdchk(bmc_pkg::STATUS_ADDR, 8'h00);
    stop_test();
  end
endmodule : bmc_ctrl_tb_top
`default_nettype wire
